// File: logic/dspsc_regs.sv
// control/status bank between the host core and the command-list unit
// assumes unit events are one-cycle pulses on the same clock
// Notes on behaviour
// - loop register: count in bits 31..16, jump target in bits 15..0.
// - host reads/writes loop register; unit loads it and reads it for stores.
// - decrement-and-jump command decrements the count field.
// - abort write halts execution, clears overflow, hold, halt flag and mask.
// - abort location is write-only and host-only; reads give zero.
// - external reference proceeds when hold is 0, stalls while it is 1.
// - hold bit is host read/write, cleared by reset and abort.
// - run bit reads 1 while executing, 0 idle, cleared on reset.
// - halt flag sets each time the unit stops execution; an abort stop does not set it.
// - halt flag is read-only, cleared by read, abort and reset.
// - interrupt request when halt flag and its mask bit are both 1.
// - mask register host read/write, cleared by reset and abort.
// - nonmaskable source: error bit 2, undefined bit 1, pin bit 0.
// - error bit sets on host access to unit space while running, exempt bank.
// - undefined bit sets on breakpoint or reserved command attempt.
// - pin bit sets on a falling edge of the active-low pin.
// - any nonmaskable source bit set raises the nonmaskable request.
// - nonmaskable source clears on reset and on every read.
// - decode RAM, dedicated and control ranges; gaps read zero.
// - pointer write starts execution; pointer accessible only while idle.
// - overflow and saturation bits clear on reset and abort.
`timescale 1ns/1ps
`default_nettype none
module dspsc_regs (
    // clock, reset, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // host side
    input wire dspsc_pkg::dspsc_host_req_t host_req,
    output logic [31:0] rdata_q,
    output logic rvalid_q,
    output logic halt_irq,
    output logic nmi_req,
    // pins
    input wire logic nmi_pin_n,
    // command-list unit side
    input wire dspsc_pkg::dspsc_unit_evt_t unit_evt,
    output logic seq_start_q,
    output logic seq_abort_q,
    output logic [15:0] cmd_ptr_q,
    output logic [31:0] loop_q,
    output logic ext_grant,
    output logic ext_stall,
    output logic run
);
    // ==========================================
    // state
    dspsc_pkg::dspsc_state_t st_q, st_d;
    logic stall_q, stall_d;
    logic flag_q, flag_d;
    logic mask_q, mask_d;
    logic [2:0] nmi_q, nmi_d;
    logic [1:0] ovf_q, ovf_d;
    logic [31:0] loop_d, rdata_d;
    logic [15:0] ptr_d;
    logic start_d, abort_d;
    logic s1_q, s2_q, s3_q;
    // ==========================================
    // decode
    logic [31:0] a;
    logic acc, in_unit, in_csr, err_evt, abort_wr, blocked, nmi_edge;
    assign a = host_req.addr;
    assign acc = host_req.wr | host_req.rd;
    assign in_csr = (a >= dspsc_pkg::CSR_BASE) && (a < dspsc_pkg::CSR_END);
    assign in_unit = in_csr
        || ((a >= dspsc_pkg::RAM_BASE) && (a < dspsc_pkg::RAM_END))
        || ((a >= dspsc_pkg::DED_BASE) && (a < dspsc_pkg::DED_END));
    assign err_evt = acc && run && in_unit && !in_csr;
    // dedicated registers are frozen to the host while running
    assign blocked = run && !in_csr;
    assign abort_wr = host_req.wr && (a == dspsc_pkg::A_ABORT);
    assign nmi_edge = s3_q && !s2_q;
    assign run = (st_q == dspsc_pkg::ST_RUN);
    assign halt_irq = flag_q && mask_q;
    assign nmi_req = |nmi_q;
    assign ext_grant = unit_evt.ext_req && !stall_q;
    assign ext_stall = unit_evt.ext_req && stall_q;
    // ==========================================
    // next values
    always_comb begin
        st_d = st_q;
        stall_d = stall_q;
        flag_d = flag_q;
        mask_d = mask_q;
        nmi_d = nmi_q;
        ovf_d = ovf_q;
        loop_d = loop_q;
        ptr_d = cmd_ptr_q;
        start_d = 1'b0;
        abort_d = 1'b0;
        rdata_d = 32'h00000000;
        // read data is sampled before any read-clear below
        if (host_req.rd && !blocked) begin
            unique case (a)
                dspsc_pkg::A_OVF: rdata_d = {30'h0, ovf_q};
                dspsc_pkg::A_LOOP: rdata_d = loop_q;
                dspsc_pkg::A_PTR: rdata_d = {16'h0, cmd_ptr_q};
                dspsc_pkg::A_RUN: rdata_d = {31'h0, run};
                dspsc_pkg::A_HFLAG: rdata_d = {31'h0, flag_q};
                dspsc_pkg::A_HMASK: rdata_d = {31'h0, mask_q};
                dspsc_pkg::A_GATE: rdata_d = {31'h0, stall_q};
                dspsc_pkg::A_NMI: rdata_d = {29'h0, nmi_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
        // read clears; a same-cycle set below still wins
        if (host_req.rd && (a == dspsc_pkg::A_HFLAG)) begin
            flag_d = 1'b0;
        end
        if (host_req.rd && (a == dspsc_pkg::A_NMI)) begin
            nmi_d = dspsc_pkg::NMI_RST;
        end
        if (host_req.rd && !blocked && (a == dspsc_pkg::A_OVF)) begin
            ovf_d = dspsc_pkg::OVF_RST;
        end
        // host writes, upper bits of narrow registers dropped
        if (host_req.wr && !blocked) begin
            if (a == dspsc_pkg::A_LOOP) begin
                loop_d = host_req.wdata;
            end
            if (a == dspsc_pkg::A_PTR) begin
                ptr_d = host_req.wdata[15:0];
                st_d = dspsc_pkg::ST_RUN;
                start_d = 1'b1;
            end
            if (a == dspsc_pkg::A_GATE) begin
                stall_d = host_req.wdata[dspsc_pkg::BIT_STALL];
            end
            if (a == dspsc_pkg::A_HMASK) begin
                mask_d = host_req.wdata[dspsc_pkg::BIT_HALT];
            end
        end
        // unit side
        if (unit_evt.load_loop) begin
            loop_d = unit_evt.loop_in;
        end else if (unit_evt.dec && run) begin
            loop_d[31:dspsc_pkg::CNT_LSB] = loop_q[31:dspsc_pkg::CNT_LSB] - 16'h0001;
        end
        if (unit_evt.ptr_upd && run) begin
            ptr_d = unit_evt.ptr_in;
        end
        if (unit_evt.ovf_set) begin
            ovf_d[dspsc_pkg::BIT_OVF] = 1'b1;
        end
        if (unit_evt.sat_set) begin
            ovf_d[dspsc_pkg::BIT_SAT] = 1'b1;
        end
        if (run && unit_evt.stopped) begin
            st_d = dspsc_pkg::ST_IDLE;
            flag_d = 1'b1;
        end
        // sources of the nonmaskable request
        if (err_evt) begin
            nmi_d[dspsc_pkg::NMI_ERR] = 1'b1;
        end
        if (unit_evt.undef_cmd) begin
            nmi_d[dspsc_pkg::NMI_UND] = 1'b1;
        end
        if (nmi_edge) begin
            nmi_d[dspsc_pkg::NMI_EXT] = 1'b1;
        end
        // abort overrides everything it clears
        if (abort_wr) begin
            st_d = dspsc_pkg::ST_IDLE;
            abort_d = 1'b1;
            start_d = 1'b0;
            stall_d = 1'b0;
            flag_d = 1'b0;
            mask_d = 1'b0;
            ovf_d = dspsc_pkg::OVF_RST;
        end
    end
    // ==========================================
    // registers
    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= dspsc_pkg::ST_IDLE;
            stall_q <= 1'b0;
            flag_q <= 1'b0;
            mask_q <= 1'b0;
            nmi_q <= dspsc_pkg::NMI_RST;
            ovf_q <= dspsc_pkg::OVF_RST;
            loop_q <= dspsc_pkg::LOOP_RST;
            cmd_ptr_q <= dspsc_pkg::PTR_RST;
            seq_start_q <= 1'b0;
            seq_abort_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rvalid_q <= 1'b0;
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else if (ce) begin
            st_q <= st_d;
            stall_q <= stall_d;
            flag_q <= flag_d;
            mask_q <= mask_d;
            nmi_q <= nmi_d;
            ovf_q <= ovf_d;
            loop_q <= loop_d;
            cmd_ptr_q <= ptr_d;
            seq_start_q <= start_d;
            seq_abort_q <= abort_d;
            rdata_q <= rdata_d;
            rvalid_q <= host_req.rd;
            s1_q <= nmi_pin_n;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // ==========================================
    // checks
    property p_abort_clr;
        @(posedge clock) disable iff (rst)
        ce && abort_wr |=> !run && !stall_q && !flag_q && !mask_q && ovf_q == 2'h0;
    endproperty
    a_abort_clr: assert property (p_abort_clr) else $error("abort left state");
    property p_abort_pulse;
        @(posedge clock) disable iff (rst)
        ce && abort_wr |=> seq_abort_q && !seq_start_q;
    endproperty
    a_abort_pulse: assert property (p_abort_pulse) else $error("no abort pulse");
    property p_stall;
        @(posedge clock) disable iff (rst)
        unit_evt.ext_req |-> (ext_stall == stall_q) && (ext_grant != stall_q);
    endproperty
    a_stall: assert property (p_stall) else $error("hold gate wrong");
    property p_halt_set;
        @(posedge clock) disable iff (rst)
        ce && run && unit_evt.stopped && !abort_wr |=> flag_q && !run;
    endproperty
    a_halt_set: assert property (p_halt_set) else $error("halt flag not set");
    property p_halt_rc;
        @(posedge clock) disable iff (rst)
        ce && host_req.rd && a == dspsc_pkg::A_HFLAG && !unit_evt.stopped |=> !flag_q;
    endproperty
    a_halt_rc: assert property (p_halt_rc) else $error("halt flag not cleared");
    property p_err;
        @(posedge clock) disable iff (rst)
        ce && acc && run && a == dspsc_pkg::A_LOOP |=> nmi_q[2] && nmi_req;
    endproperty
    a_err: assert property (p_err) else $error("error bit not set");
    property p_pin;
        @(posedge clock) disable iff (rst)
        ce && nmi_pin_n ##1 ce && !nmi_pin_n ##1 ce [*2] |=> nmi_q[0];
    endproperty
    a_pin: assert property (p_pin) else $error("pin edge lost");
    property p_nmi_rc;
        @(posedge clock) disable iff (rst)
        ce && host_req.rd && a == dspsc_pkg::A_NMI && !err_evt && !unit_evt.undef_cmd
            && !nmi_edge |=> nmi_q == 3'h0;
    endproperty
    a_nmi_rc: assert property (p_nmi_rc) else $error("source not cleared");
    property p_dec;
        @(posedge clock) disable iff (rst)
        ce && run && unit_evt.dec && !unit_evt.load_loop
            && !(host_req.wr && a == dspsc_pkg::A_LOOP)
            |=> loop_q[31:16] == $past(loop_q[31:16]) - 16'h0001;
    endproperty
    a_dec: assert property (p_dec) else $error("count not decremented");
    property p_start;
        @(posedge clock) disable iff (rst)
        ce && !run && host_req.wr && a == dspsc_pkg::A_PTR
            |=> run && seq_start_q && cmd_ptr_q == $past(host_req.wdata[15:0]);
    endproperty
    a_start: assert property (p_start) else $error("start failed");
    property p_rst;
        @(posedge clock) rst |=> !run && !halt_irq && !nmi_req;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
`default_nettype wire

// File: shared/dspsc_pkg.sv
// constants and carriers for the sequencer control/status bank
// assumes a 32-bit host address/data path on the core clock
package dspsc_pkg;
    // ==========================================
    // address map
    localparam logic [31:0] RAM_BASE = 32'hfffe0000;
    localparam logic [31:0] RAM_END = 32'hfffe1000;
    localparam logic [31:0] DED_BASE = 32'hffff8000;
    localparam logic [31:0] DED_END = 32'hffff8028;
    localparam logic [31:0] CSR_BASE = 32'hffff9000;
    localparam logic [31:0] CSR_END = 32'hffff9018;
    localparam logic [31:0] A_OVF = 32'hffff8004;
    localparam logic [31:0] A_LOOP = 32'hffff8018;
    localparam logic [31:0] A_PTR = 32'hffff8020;
    localparam logic [31:0] A_RUN = 32'hffff9000;
    localparam logic [31:0] A_ABORT = 32'hffff9004;
    localparam logic [31:0] A_HFLAG = 32'hffff9008;
    localparam logic [31:0] A_HMASK = 32'hffff900c;
    localparam logic [31:0] A_GATE = 32'hffff9010;
    localparam logic [31:0] A_NMI = 32'hffff9014;
    // ==========================================
    // fields
    localparam int CNT_LSB = 16;
    localparam int BIT_STALL = 0;
    localparam int BIT_ACTIVE = 0;
    localparam int BIT_HALT = 0;
    localparam int BIT_OVF = 0;
    localparam int BIT_SAT = 1;
    localparam int NMI_ERR = 2;
    localparam int NMI_UND = 1;
    localparam int NMI_EXT = 0;
    // ==========================================
    // reset values
    localparam logic [31:0] LOOP_RST = 32'h00000000;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [2:0] NMI_RST = 3'h0;
    localparam logic [1:0] OVF_RST = 2'h0;
    // ==========================================
    // carriers
    typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} dspsc_state_t;
    typedef struct packed {
        logic [31:0] addr;
        logic wr;
        logic rd;
        logic [31:0] wdata;
    } dspsc_host_req_t;
    typedef struct packed {
        logic stopped;
        logic load_loop;
        logic [31:0] loop_in;
        logic dec;
        logic undef_cmd;
        logic ovf_set;
        logic sat_set;
        logic ptr_upd;
        logic [15:0] ptr_in;
        logic ext_req;
    } dspsc_unit_evt_t;
endpackage

// File: sim/dspsc_unit_model.sv
// command-list unit stand-in: pulses unit events when the bench asks
// assumes the bank samples events on the rising edge of clock
`timescale 1ns/1ps
`default_nettype none
module dspsc_unit_model (
    // clock
    input wire logic clock,
    // bank side
    output var dspsc_pkg::dspsc_unit_evt_t unit_evt
);
    logic ext_lvl = 1'b0;
    initial unit_evt = '0;
    // ==========================================
    // one-cycle event pulses
    // k: 0 stop, 1 load loop, 2 decrement, 3 undefined, 4 overflow, 6 pointer, else saturation
    task automatic fire(input int k, input logic [31:0] v);
        dspsc_pkg::dspsc_unit_evt_t ev;
        ev = '{ext_req: ext_lvl, loop_in: v, ptr_in: v[15:0], default: '0};
        case (k)
            0: ev.stopped = 1'b1;
            1: ev.load_loop = 1'b1;
            2: ev.dec = 1'b1;
            3: ev.undef_cmd = 1'b1;
            4: ev.ovf_set = 1'b1;
            6: ev.ptr_upd = 1'b1;
            default: ev.sat_set = 1'b1;
        endcase
        @(posedge clock);
        unit_evt <= ev;
        @(posedge clock);
        // data flips after the pulse so a late sample cannot match by luck
        unit_evt <= '{ext_req: ext_lvl, loop_in: ~v, ptr_in: ~v[15:0], default: '0};
    endtask
    // ==========================================
    // external reference request, a level
    task automatic set_ext(input logic b);
        @(posedge clock);
        ext_lvl = b;
        unit_evt.ext_req <= b;
    endtask
endmodule
`default_nettype wire

// File: sim/dspsc_regs_tb.sv
// self-checking bench for the sequencer control/status bank
// assumes the package and the unit model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module dspsc_regs_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic nmi_pin_n = 1'b1;
    dspsc_pkg::dspsc_host_req_t host_req = '0;
    dspsc_pkg::dspsc_unit_evt_t unit_evt;
    logic [31:0] rdata_q, loop_q, lv, r;
    logic rvalid_q, halt_irq, nmi_req, run, ext_grant, ext_stall;
    logic seq_start_q, seq_abort_q;
    // locations that read zero after reset and after an abort
    logic [31:0] amap[6] = '{dspsc_pkg::A_HMASK, dspsc_pkg::A_GATE, dspsc_pkg::A_OVF,
        dspsc_pkg::A_HFLAG, dspsc_pkg::A_ABORT, dspsc_pkg::A_RUN};
    logic [15:0] cmd_ptr_q;
    logic [31:0] exp_q[$];
    int check_count = 0;
    int mismatches = 0;
    int cycles = 0;
    always #10 clock = ~clock;
    dspsc_regs i_dspsc_regs (.clock(clock), .rst(rst), .ce(ce), .host_req(host_req),
        .rdata_q(rdata_q), .rvalid_q(rvalid_q), .halt_irq(halt_irq), .nmi_req(nmi_req),
        .nmi_pin_n(nmi_pin_n), .unit_evt(unit_evt), .seq_start_q(seq_start_q),
        .seq_abort_q(seq_abort_q),
        .cmd_ptr_q(cmd_ptr_q), .loop_q(loop_q), .ext_grant(ext_grant),
        .ext_stall(ext_stall), .run(run));
    dspsc_unit_model i_dspsc_unit_model (.clock(clock), .unit_evt(unit_evt));
    // ==========================================
    // host accesses; reads leave their expectation in the queue
    task automatic acc(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        host_req <= '{addr: a, wr: w, rd: ~w, wdata: d};
        @(posedge clock);
        host_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        acc(a, 1'b0, 32'h0);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ==========================================
    // read data monitor
    always @(posedge clock) begin
        if (rvalid_q === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK("rdata_extra", 1'b0, 1'b1)
            end else begin
                `CHK("rdata", exp_q[0], rdata_q)
                void'(exp_q.pop_front());
            end
        end
    end
    // hang guard, the run needs under 150 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            close_out();
        end
    end
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(82358));
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        foreach (amap[i]) rd(amap[i], 32'h0);
        r = $urandom();
        lv = {r[31:16] | 16'h0001, r[15:0]};
        acc(dspsc_pkg::A_HMASK, 1'b1, r | 32'h1);
        rd(dspsc_pkg::A_HMASK, 32'h1);
        acc(dspsc_pkg::A_GATE, 1'b1, ~r | 32'h1);
        rd(dspsc_pkg::A_GATE, 32'h1);
        acc(dspsc_pkg::A_LOOP, 1'b1, lv);
        rd(dspsc_pkg::A_LOOP, lv);
        rd(32'hffff9018, 32'h0);
        rd(32'hffff8028, 32'h0);
        i_dspsc_unit_model.set_ext(1'b1);
        @(negedge clock);
        `CHK("stall", 2'b10, {ext_stall, ext_grant})
        acc(dspsc_pkg::A_GATE, 1'b1, 32'h0);
        @(negedge clock);
        `CHK("grant", 2'b01, {ext_stall, ext_grant})
        i_dspsc_unit_model.set_ext(1'b0);
        acc(dspsc_pkg::A_PTR, 1'b1, 32'h0040);
        @(negedge clock);
        `CHK("start", 17'h10040, {run, cmd_ptr_q})
        `CHK("start_pulse", 1'b1, seq_start_q)
        rd(dspsc_pkg::A_RUN, 32'h1);
        rd(dspsc_pkg::A_LOOP, 32'h0);
        @(negedge clock);
        `CHK("nmi_err", 1'b1, nmi_req)
        rd(dspsc_pkg::A_NMI, 32'h4);
        rd(dspsc_pkg::A_NMI, 32'h0);
        i_dspsc_unit_model.fire(2, 32'h0);
        @(negedge clock);
        `CHK("count", lv[31:16] - 16'h0001, loop_q[31:16])
        i_dspsc_unit_model.fire(6, 32'h00001234);
        @(negedge clock);
        `CHK("ptr_upd", 16'h1234, cmd_ptr_q)
        i_dspsc_unit_model.fire(0, 32'h0);
        @(negedge clock);
        `CHK("halt", 2'b01, {run, halt_irq})
        rd(dspsc_pkg::A_HFLAG, 32'h1);
        @(negedge clock);
        `CHK("irq_clr", 1'b0, halt_irq)
        rd(dspsc_pkg::A_HFLAG, 32'h0);
        i_dspsc_unit_model.fire(4, 32'h0);
        rd(dspsc_pkg::A_OVF, 32'h1);
        i_dspsc_unit_model.fire(5, 32'h0);
        rd(dspsc_pkg::A_OVF, 32'h2);
        acc(dspsc_pkg::A_GATE, 1'b1, 32'h1);
        acc(dspsc_pkg::A_PTR, 1'b1, 32'h0);
        i_dspsc_unit_model.fire(4, 32'h0);
        acc(dspsc_pkg::A_ABORT, 1'b1, r);
        @(negedge clock);
        `CHK("abort", 2'b00, {run, nmi_req})
        `CHK("abort_pulse", 1'b1, seq_abort_q)
        foreach (amap[i]) rd(amap[i], 32'h0);
        i_dspsc_unit_model.fire(3, 32'h0);
        @(negedge clock);
        `CHK("nmi_und", 1'b1, nmi_req)
        rd(dspsc_pkg::A_NMI, 32'h2);
        @(posedge clock);
        nmi_pin_n <= 1'b0;
        repeat (5) @(posedge clock);
        rd(dspsc_pkg::A_NMI, 32'h1);
        nmi_pin_n <= 1'b1;
        r = $urandom();
        i_dspsc_unit_model.fire(1, r);
        @(negedge clock);
        `CHK("load", r, loop_q)
        rd(dspsc_pkg::A_LOOP, r);
        // let the read strobe retire before freezing, or rvalid would stick
        @(posedge clock);
        ce <= 1'b0;
        i_dspsc_unit_model.fire(1, ~r);
        ce <= 1'b1;
        @(negedge clock);
        `CHK("freeze", r, loop_q)
        // second reset in mid-run, with state set beforehand
        acc(dspsc_pkg::A_HMASK, 1'b1, 32'h1);
        acc(dspsc_pkg::A_GATE, 1'b1, 32'h1);
        i_dspsc_unit_model.fire(3, 32'h0);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        `CHK("rst_out", 3'b000, {run, nmi_req, halt_irq})
        foreach (amap[i]) rd(amap[i], 32'h0);
        rd(dspsc_pkg::A_NMI, 32'h0);
        rd(dspsc_pkg::A_LOOP, dspsc_pkg::LOOP_RST);
        repeat (4) @(posedge clock);
        `CHK("pending", 0, exp_q.size())
        close_out();
    end
endmodule
`default_nettype wire
